// File: hdl/rio_pkg.sv
// Purpose: Constants for the relay indicator latching and output routing.
// Assumes: One 100 MHz clock, synchronous active-low reset, AXI4-Lite.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
//
// Notes on behaviour
// - Supply indicator follows the power supply's operating report one clock later.
// - Option keeps start indications shown after the stage resets.
// - Starts clear with their stage by default; trips latch until push-button.
// - Option lets the general trip indicator also show starting.
// - Blocking inputs and remote clear may each clear latched trips.
// - Indicator state never gates stage start or trip signals.
// - Permanent self-supervision fault lights fault indicator and shows fault code.
// - Eight output relays plus internal-fault relay; five control inputs.
// - Each stage start and trip output drives whichever relays its route mask selects.
// - Switch settings choose which relays each stage operation drives.
// - Switches assign control inputs to blocking, relay reset or bank select.
// - Alarm when any secondary supply deviates more than 25 percent.
package rio_pkg;
	localparam int NSTG = 8;
	localparam int NIN = 5;
	localparam int NREL = 8;
	// Byte offsets.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_INDIC = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_MASK = 8'h0c;
	localparam logic [7:0] OFS_INPUTS = 8'h10;
	localparam logic [7:0] OFS_FCODE = 8'h14;
	localparam logic [7:0] OFS_SROUTE = 8'h20;
	localparam logic [7:0] OFS_TROUTE = 8'h40;
	localparam logic [7:0] OFS_INFUNC = 8'h60;
	// Control register fields.
	localparam int CTRL_HOLD_START = 0;
	localparam int CTRL_TRIP_SHOWS_START = 1;
	localparam int CTRL_CLEAR_BUTTON = 2;
	localparam int CTRL_RELAY_LATCH = 3;
	// Input function fields.
	localparam int FN_CLR_IND = 0;
	localparam int FN_CLR_RELAY = 1;
	localparam int FN_BANK2 = 2;
	localparam int FN_BLOCK = 8;
	// Status event bits.
	localparam int EV_TRIP = 0;
	localparam int EV_START = 1;
	localparam int EV_FAULT = 2;
	localparam int EV_SUPPLY = 3;
	// Push-button clears indications out of reset, as the default asks.
	localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Supply deviation limit, in percent of rated value.
	localparam int SUPPLY_DEV_PCT = 25;
endpackage

// File: hdl/rio_core.sv
// Purpose: Indicator latching, relay routing and AXI4-Lite registers.
// Assumes: Stage and supply inputs are synchronous to aclk.
// Notes: Supply levels are 16-bit codes compared to rated codes.
`timescale 1ns/1ps
module rio_core
	import rio_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [rio_pkg::NSTG-1:0] stage_start,
	input wire logic [rio_pkg::NSTG-1:0] stage_trip,
	input wire logic block_input_one,
	input wire logic block_input_two,
	input wire logic [2:0] user_inputs,
	input wire logic remote_indication_clear,
	input wire logic reset_button,
	input wire logic psu_operating,
	input wire logic perm_fault,
	input wire logic [7:0] perm_fault_code,
	input wire logic [15:0] supply_level,
	input wire logic [15:0] supply_rated,
	output logic supply_on_indicator,
	output logic [3:0] signalling_outputs,
	output logic [3:0] breaker_trip_outputs,
	output logic internal_fault_output,
	output logic fault_indicator,
	output logic supervision_alarm,
	output logic general_trip_indicator,
	output logic [rio_pkg::NSTG-1:0] start_indication,
	output logic [rio_pkg::NSTG-1:0] trip_indication,
	output logic [rio_pkg::NSTG-1:0] stage_block,
	output logic bank2_select,
	output logic [7:0] fault_code,
	output logic irq,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import rio_pkg::*;

	// All checks share the one clock and stay quiet while reset is held.
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ----------------------------------------
	// Configuration state
	// ----------------------------------------
	logic [31:0] ctrl;
	logic [3:0] stat;
	logic [3:0] mask;
	logic [NREL-1:0] sroute [NSTG];
	logic [NREL-1:0] troute [NSTG];
	logic [15:0] infunc [NIN];
	logic [NSTG-1:0] start_lat, trip_lat;
	logic [NREL-1:0] relay_lat;
	logic [NIN-1:0] ins;
	logic [NSTG-1:0] blk, gstart, gtrip;
	logic [NIN-1:0] fn_clr_ind, fn_clr_rel, fn_bank;
	logic clr_ind, clr_rel, supply_dev;
	logic [NREL-1:0] relay_now;

	// Byte-enable merge, used by the control and input function register writes.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// Control inputs and stage gating
	// ----------------------------------------
	assign ins = {remote_indication_clear, block_input_two, user_inputs[2],
		user_inputs[1], block_input_one};

	// Each input is steered by its own function word.
	always_comb begin
		blk = '0;
		for (int i = 0; i < NIN; i++) begin
			fn_clr_ind[i] = ins[i] & infunc[i][FN_CLR_IND];
			fn_clr_rel[i] = ins[i] & infunc[i][FN_CLR_RELAY];
			fn_bank[i] = ins[i] & infunc[i][FN_BANK2];
			if (ins[i]) begin
				blk = blk | infunc[i][FN_BLOCK +: NSTG];
			end
		end
	end

	assign clr_ind = (reset_button & ctrl[CTRL_CLEAR_BUTTON]) | (|fn_clr_ind);
	assign clr_rel = reset_button | (|fn_clr_rel);
	// Indicators never feed back, so blocking comes only from inputs.
	assign gstart = stage_start & ~blk;
	assign gtrip = stage_trip & ~blk;

	// ----------------------------------------
	// Indication latches
	// ----------------------------------------
	// A new trip outranks a clear so no event is lost.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trip_lat <= '0;
		end else begin
			trip_lat <= (clr_ind ? '0 : trip_lat) | gtrip;
		end
	end

	// Starts either follow the stage or are held until a clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_lat <= '0;
		end else if (ctrl[CTRL_HOLD_START]) begin
			start_lat <= (clr_ind ? '0 : start_lat) | gstart;
		end else begin
			start_lat <= gstart;
		end
	end

	assign start_indication = start_lat;
	assign trip_indication = trip_lat;
	assign general_trip_indicator = (|trip_lat) |
		(ctrl[CTRL_TRIP_SHOWS_START] & (|start_lat));

	// ----------------------------------------
	// Relay routing
	// ----------------------------------------
	// Any stage operation may drive any relay through its route mask.
	always_comb begin
		relay_now = '0;
		for (int s = 0; s < NSTG; s++) begin
			relay_now = relay_now | ({NREL{gstart[s]}} & sroute[s]) |
				({NREL{gtrip[s]}} & troute[s]);
		end
	end

	// Latched relays hold until a button or input clear; new wins.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			relay_lat <= '0;
		end else begin
			relay_lat <= (clr_rel ? '0 : relay_lat) | relay_now;
		end
	end

	// Relays come from flip-flops; bits 3:0 signal, 7:4 trip.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			signalling_outputs <= '0;
			breaker_trip_outputs <= '0;
		end else begin
			signalling_outputs <= relay_now[3:0] |
				({4{ctrl[CTRL_RELAY_LATCH]}} & relay_lat[3:0]);
			breaker_trip_outputs <= relay_now[7:4] |
				({4{ctrl[CTRL_RELAY_LATCH]}} & relay_lat[7:4]);
		end
	end

	// ----------------------------------------
	// Supply and self-supervision
	// ----------------------------------------
	// Deviation test scaled by 100 to avoid a divider.
	always_comb begin
		logic [15:0] diff;
		diff = (supply_level > supply_rated) ? supply_level - supply_rated
			: supply_rated - supply_level;
		supply_dev = (25'(diff) * 25'd100) >
			(25'(supply_rated) * 25'(SUPPLY_DEV_PCT));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			supply_on_indicator <= 1'b0;
			fault_indicator <= 1'b0;
			internal_fault_output <= 1'b0;
			supervision_alarm <= 1'b0;
			fault_code <= '0;
			bank2_select <= 1'b0;
			stage_block <= '0;
		end else begin
			supply_on_indicator <= psu_operating;
			fault_indicator <= perm_fault;
			internal_fault_output <= perm_fault | supply_dev;
			supervision_alarm <= supply_dev;
			if (perm_fault) begin
				fault_code <= perm_fault_code;
			end
			bank2_select <= |fn_bank;
			stage_block <= blk;
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	logic aw_h, w_h;
	logic [7:0] aw_a;
	logic [31:0] w_d;
	logic [3:0] w_s;
	logic do_wr;
	logic [3:0] ev, w1c;

	assign s_axi_awready = !aw_h && !s_axi_bvalid;
	assign s_axi_wready = !w_h && !s_axi_bvalid;
	assign do_wr = aw_h && w_h && !s_axi_bvalid;
	assign ev = {supply_dev, perm_fault, |gstart, |gtrip};
	assign w1c = (do_wr && aw_a == OFS_STAT && w_s[0]) ? w_d[3:0] : 4'h0;
	assign irq = |(stat & mask);

	// Address and data are captured independently in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_h <= 1'b0;
			w_h <= 1'b0;
			aw_a <= '0;
			w_d <= '0;
			w_s <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_h <= 1'b1;
				aw_a <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_h <= 1'b1;
				w_d <= s_axi_wdata;
				w_s <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_h <= 1'b0;
				w_h <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_a <= OFS_FCODE || aw_a >= OFS_SROUTE)
					&& aw_a < OFS_INFUNC + 8'(4*NIN)
					&& aw_a[1:0] == 2'b00 ? RESP_OKAY
					: RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Register writes; status sets win over write-one-to-clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= CTRL_RESET;
			mask <= '0;
			stat <= '0;
			for (int i = 0; i < NSTG; i++) begin
				sroute[i] <= '0;
				troute[i] <= '0;
			end
			for (int i = 0; i < NIN; i++) begin
				infunc[i] <= '0;
			end
		end else begin
			stat <= (stat & ~w1c) | ev;
			if (do_wr) begin
				if (aw_a == OFS_CTRL) ctrl <= merge(ctrl, w_d, w_s);
				if (aw_a == OFS_MASK && w_s[0]) mask <= w_d[3:0];
				for (int i = 0; i < NSTG; i++) begin
					if (aw_a == OFS_SROUTE + 8'(4*i) && w_s[0])
						sroute[i] <= w_d[NREL-1:0];
					if (aw_a == OFS_TROUTE + 8'(4*i) && w_s[0])
						troute[i] <= w_d[NREL-1:0];
				end
				for (int i = 0; i < NIN; i++) begin
					if (aw_a == OFS_INFUNC + 8'(4*i))
						infunc[i] <= 16'(merge({16'h0, infunc[i]}, w_d, w_s));
				end
			end
		end
	end

	// Read channel: one read in flight; unmapped reads give SLVERR.
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= '0;
			case (s_axi_araddr)
				OFS_CTRL: s_axi_rdata <= ctrl;
				OFS_INDIC: s_axi_rdata <= {16'h0, trip_lat, start_lat};
				OFS_STAT: s_axi_rdata <= {28'h0, stat};
				OFS_MASK: s_axi_rdata <= {28'h0, mask};
				OFS_INPUTS: s_axi_rdata <= {27'h0, ins};
				OFS_FCODE: s_axi_rdata <= {24'h0, fault_code};
				default: begin
					s_axi_rresp <= RESP_SLVERR;
					for (int i = 0; i < NSTG; i++) begin
						if (s_axi_araddr == OFS_SROUTE + 8'(4*i)) begin
							s_axi_rdata <= {24'h0, sroute[i]};
							s_axi_rresp <= RESP_OKAY;
						end
						if (s_axi_araddr == OFS_TROUTE + 8'(4*i)) begin
							s_axi_rdata <= {24'h0, troute[i]};
							s_axi_rresp <= RESP_OKAY;
						end
					end
					for (int i = 0; i < NIN; i++) begin
						if (s_axi_araddr == OFS_INFUNC + 8'(4*i)) begin
							s_axi_rdata <= {16'h0, infunc[i]};
							s_axi_rresp <= RESP_OKAY;
						end
					end
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_trip_and_clear;
		(|gtrip) && clr_ind;
	endsequence

	a_supply_led_follows: assert property (
		psu_operating |=> supply_on_indicator)
		else $error("Supply indicator not lit while supply operates.");
	a_start_hold_kept: assert property (
		ctrl[CTRL_HOLD_START] && !clr_ind |=>
		(start_lat & $past(start_lat)) == $past(start_lat))
		else $error("Held start indication was dropped.");
	a_start_follows_stage: assert property (
		!ctrl[CTRL_HOLD_START] |=> start_lat == $past(gstart))
		else $error("Start indication did not follow its stage.");
	a_trip_latch_hold: assert property (
		!clr_ind |=> (trip_lat & $past(trip_lat)) == $past(trip_lat))
		else $error("Trip indication cleared without a reset.");
	a_gen_trip_start: assert property (
		ctrl[CTRL_TRIP_SHOWS_START] && (|start_lat) |->
		general_trip_indicator)
		else $error("General trip indicator ignores starts.");
	a_input_clears_trip: assert property (
		block_input_one && infunc[0][FN_CLR_IND] && !(|gtrip) |=>
		trip_lat == '0)
		else $error("Blocking input did not clear trips.");
	a_trip_passes_relay: assert property (
		gtrip[0] && troute[0][4] |=> breaker_trip_outputs[0])
		else $error("Routed trip did not reach its relay.");
	a_fault_code_shown: assert property (
		perm_fault |=> fault_indicator &&
		fault_code == $past(perm_fault_code))
		else $error("Permanent fault not indicated.");
	a_supply_alarm: assert property (
		supply_dev |=> supervision_alarm && internal_fault_output)
		else $error("Supply deviation gave no alarm.");
	a_trip_beats_clear: assert property (
		s_trip_and_clear |=> trip_lat == $past(gtrip))
		else $error("New trip lost under a reset.");
endmodule

// File: dv/rio_field.sv
// Purpose: Switchgear wiring and external control contacts for the bench.
// Assumes: The bench asks for contact states through cmd, one bit an input.
// Notes: Contacts change one clock edge after cmd, as a slow contact would.
`timescale 1ns/1ps
module rio_field (
	input wire logic aclk,
	input wire logic [4:0] cmd,
	input wire logic [3:0] breaker_trip_outputs,
	input wire logic [3:0] signalling_outputs,
	output logic block_input_one = 1'b0,
	output logic block_input_two = 1'b0,
	output logic [2:0] user_inputs = 3'h0,
	output logic remote_indication_clear = 1'b0,
	output logic breaker_open,
	output logic annunciator
);
	// Contacts follow the request; user input zero has no wiring here.
	always @(posedge aclk) begin
		block_input_one <= cmd[0];
		user_inputs <= {cmd[2], cmd[1], 1'b0};
		block_input_two <= cmd[3];
		remote_indication_clear <= cmd[4];
	end
	// Only heavy-duty relays reach the breaker coil, never the signal relays.
	assign breaker_open = |breaker_trip_outputs;
	assign annunciator = |signalling_outputs;
endmodule

// File: dv/relay_indicator_output_routing_tb.sv
// Purpose: Self-checking bench for indicator latching and relay routing.
// Assumes: Design reached only through its pins and AXI4-Lite registers.
// Notes: Waits of four edges cover input, latch and relay register stages.
`timescale 1ns/1ps
module relay_indicator_output_routing_tb;
	import rio_pkg::*;
	logic aclk = 1'b0, aresetn = 1'b0, reset_button = 1'b0;
	logic psu_operating = 1'b0, perm_fault = 1'b0;
	logic [NSTG-1:0] stage_start = '0, stage_trip = '0;
	logic [7:0] perm_fault_code = 8'h00;
	logic [15:0] supply_level = 16'd1000, supply_rated = 16'd1000;
	logic block_input_one, block_input_two, remote_indication_clear;
	logic [2:0] user_inputs;
	logic supply_on_indicator, internal_fault_output, fault_indicator;
	logic supervision_alarm, general_trip_indicator, bank2_select, irq;
	logic [3:0] signalling_outputs, breaker_trip_outputs;
	logic [NSTG-1:0] start_indication, trip_indication, stage_block;
	logic [7:0] fault_code, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, breaker_open, annunciator;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [4:0] cmd = 5'h00;
	int miscompares = 0, checks_done = 0, cycles = 0;
	rio_core dut (.*);
	rio_field u_field (.aclk(aclk), .cmd(cmd),
		.breaker_trip_outputs(breaker_trip_outputs),
		.signalling_outputs(signalling_outputs),
		.block_input_one(block_input_one), .block_input_two(block_input_two),
		.user_inputs(user_inputs),
		.remote_indication_clear(remote_indication_clear),
		.breaker_open(breaker_open), .annunciator(annunciator));
	// Clock and a watchdog; the ceiling is far above the expected run.
	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			print_verdict();
		end
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Lets the updates of the last edge land before outputs are judged.
	task automatic step(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask
	// Address and data go out together; each drops once it is taken.
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		chk(s_axi_bresp, er);
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		chk(s_axi_rdata & m, ed);
		chk(s_axi_rresp, er);
	endtask
	task automatic drive(input logic [7:0] st, input logic [7:0] tr);
		@(posedge aclk);
		stage_start <= st;
		stage_trip <= tr;
	endtask
	task automatic press();
		@(posedge aclk);
		reset_button <= 1'b1;
		@(posedge aclk);
		reset_button <= 1'b0;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_supply();
		@(posedge aclk);
		psu_operating <= 1'b1;
		#1 chk(supply_on_indicator, 0);
		step(1);
		chk(supply_on_indicator, 1);
		@(posedge aclk);
		psu_operating <= 1'b0;
		step(2);
		chk(supply_on_indicator, 0);
	endtask
	task automatic t_latch();
		axr(OFS_CTRL, 32'hffff_ffff, CTRL_RESET, RESP_OKAY);
		axw(OFS_TROUTE + 8'h04, 32'h80, RESP_OKAY);
		drive(8'h01, 8'h02);
		step(4);
		chk(start_indication, 8'h01);
		drive(8'h00, 8'h00);
		step(4);
		chk(start_indication, 8'h00);
		chk(trip_indication, 8'h02);
		axr(OFS_INDIC, 32'hffff, 32'h0200, RESP_OKAY);
		// A held indication must not stop stage one tripping its relay.
		drive(8'h00, 8'h02);
		step(4);
		chk(breaker_trip_outputs, 4'h8);
		chk(breaker_open, 1);
		@(posedge aclk);
		stage_trip <= 8'h04;
		reset_button <= 1'b1;
		@(posedge aclk);
		stage_trip <= 8'h00;
		reset_button <= 1'b0;
		step(4);
		chk(trip_indication, 8'h04);
		press();
		step(4);
		chk(trip_indication, 8'h00);
	endtask
	task automatic t_opts();
		drive(8'h10, 8'h00);
		step(4);
		chk(general_trip_indicator, 0);
		axw(OFS_CTRL, 32'h7, RESP_OKAY);
		step(4);
		chk(general_trip_indicator, 1);
		drive(8'h00, 8'h00);
		step(4);
		chk(start_indication, 8'h10);
		press();
		step(4);
		chk(start_indication, 8'h00);
		axw(OFS_CTRL, 32'h4, RESP_OKAY);
	endtask
	task automatic t_route();
		for (int r = 0; r < NREL; r++) begin
			axw(OFS_TROUTE + 8'h0c, 32'h1 << r, RESP_OKAY);
			drive(8'h00, 8'h08);
			step(4);
			chk({breaker_trip_outputs, signalling_outputs}, 32'h1 << r);
			chk(breaker_open, (r >= 4));
			chk(annunciator, (r < 4));
			drive(8'h00, 8'h00);
			step(4);
			chk({breaker_trip_outputs, signalling_outputs}, 0);
		end
		axw(OFS_SROUTE + 8'h14, 32'h04, RESP_OKAY);
		drive(8'h20, 8'h00);
		step(4);
		chk(signalling_outputs, 4'h4);
		drive(8'h00, 8'h00);
		press();
	endtask
	task automatic t_inputs();
		int idx[3] = '{0, 3, 4};
		foreach (idx[k]) begin
			axw(OFS_INFUNC + 8'(4 * idx[k]), 32'h1, RESP_OKAY);
			drive(8'h00, 8'h01);
			drive(8'h00, 8'h00);
			step(4);
			chk(trip_indication, 8'h01);
			@(posedge aclk);
			cmd <= 5'(1 << idx[k]);
			step(4);
			chk(trip_indication, 8'h00);
			@(posedge aclk);
			cmd <= 5'h00;
			axw(OFS_INFUNC + 8'(4 * idx[k]), 32'h0, RESP_OKAY);
		end
		axw(OFS_INFUNC + 8'h04, 32'h0404, RESP_OKAY);
		@(posedge aclk);
		cmd <= 5'h02;
		step(4);
		chk(stage_block, 8'h04);
		chk(bank2_select, 1);
		axr(OFS_INPUTS, 32'h1f, 32'h02, RESP_OKAY);
		drive(8'h00, 8'h04);
		step(4);
		chk(trip_indication, 8'h00);
		@(posedge aclk);
		cmd <= 5'h00;
		stage_trip <= 8'h00;
		step(4);
		chk(bank2_select, 0);
	endtask
	// Latched relays hold after the stage drops until an input clears them.
	task automatic t_relay();
		axw(OFS_CTRL, 32'hc, RESP_OKAY);
		axr(OFS_CTRL, 32'hf, 32'hc, RESP_OKAY);
		axw(OFS_TROUTE, 32'h10, RESP_OKAY);
		drive(8'h00, 8'h01);
		drive(8'h00, 8'h00);
		step(4);
		chk(breaker_trip_outputs, 4'h1);
		axw(OFS_INFUNC + 8'h10, 32'h2, RESP_OKAY);
		@(posedge aclk);
		cmd <= 5'h10;
		step(4);
		chk(breaker_trip_outputs, 4'h0);
		@(posedge aclk);
		cmd <= 5'h00;
		axw(OFS_INFUNC + 8'h10, 32'h0, RESP_OKAY);
		axw(OFS_CTRL, 32'h4, RESP_OKAY);
		press();
		step(4);
		chk(trip_indication, 8'h00);
	endtask
	task automatic t_super();
		logic [15:0] lv[4] = '{16'd1250, 16'd1251, 16'd750, 16'd749};
		@(posedge aclk);
		perm_fault <= 1'b1;
		perm_fault_code <= 8'h5a;
		step(4);
		chk(fault_indicator, 1);
		chk(fault_code, 8'h5a);
		axr(OFS_FCODE, 32'hff, 32'h5a, RESP_OKAY);
		chk(internal_fault_output, 1);
		@(posedge aclk);
		perm_fault <= 1'b0;
		step(4);
		chk(internal_fault_output, 0);
		foreach (lv[k]) begin
			@(posedge aclk);
			supply_level <= lv[k];
			step(4);
			chk(internal_fault_output, k % 2);
			if (k == 1) chk(supervision_alarm, 1);
		end
		@(posedge aclk);
		supply_level <= 16'd1000;
	endtask
	task automatic t_irq();
		axw(OFS_STAT, 32'hf, RESP_OKAY);
		drive(8'h00, 8'h40);
		drive(8'h00, 8'h00);
		axr(OFS_STAT, 32'h1, 32'h1, RESP_OKAY);
		chk(irq, 0);
		axw(OFS_MASK, 32'h1, RESP_OKAY);
		axr(OFS_MASK, 32'hf, 32'h1, RESP_OKAY);
		step(1);
		chk(irq, 1);
		axw(OFS_STAT, 32'h1, RESP_OKAY);
		step(1);
		chk(irq, 0);
		axr(8'hfc, 32'hffff_ffff, 32'h0, RESP_SLVERR);
		axw(8'hfc, 32'h1, RESP_SLVERR);
	endtask
	// Reset for two edges, then every scenario in turn.
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_supply();
		t_latch();
		t_opts();
		t_route();
		t_inputs();
		t_relay();
		t_super();
		t_irq();
		print_verdict();
	end
endmodule
